//--- logic/rtc_params.svh
// Constants for the two-wire clock device and its bus controller.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define RTC_CLK_NS 50
`define RTC_SLAVE_ADDR 7'h68
`define RTC_CLOCK_REGS 5'h08
`define RTC_CTRL_REG 5'h08
`define RTC_FREEZE_REG 5'h0c
`define RTC_LAST_REG 5'h13
`define RTC_HALT_BIT 7
`define RTC_CEN_EN_BIT 7
`define RTC_CEN_FLAG_BIT 6
`define RTC_FREEZE_BIT 6
`define RTC_FREQ_TEST_BIT 6
`define RTC_HUNDREDTH_NS 10000000
`define RTC_RECOVERY_NS 10000
`define RTC_RECOVERY_CYC ((`RTC_RECOVERY_NS + `RTC_CLK_NS - 1) / `RTC_CLK_NS)
`define RTC_QUARTER_NS 1250
`define RTC_QUARTER_CYC ((`RTC_QUARTER_NS + `RTC_CLK_NS - 1) / `RTC_CLK_NS)
`define RTC_APB_CMD 8'h00
`define RTC_APB_TX 8'h04
`define RTC_APB_STAT 8'h08
`define RTC_APB_RX 8'h0c
`define RTC_CMD_NACK_BIT 8
`endif

//--- logic/rtc_pkg.sv
// Types shared by the clock device, its synchroniser and the bus controller.
`default_nettype none
package rtc_pkg;
	typedef enum logic [3:0] {
		S_IDLE     = 4'h0,
		S_ADDR     = 4'h1,
		S_ADDR_ACK = 4'h2,
		S_PTR      = 4'h3,
		S_PTR_ACK  = 4'h4,
		S_WDAT     = 4'h5,
		S_WDAT_ACK = 4'h6,
		S_RDAT     = 4'h7,
		S_RACK     = 4'h8,
		S_WAIT     = 4'h9
	} slave_state_e;
	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_START = 3'h1,
		OP_STOP  = 3'h2,
		OP_WRITE = 3'h3,
		OP_READ  = 3'h4
	} host_op_e;
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
	} sync_s;
	typedef struct packed {
		slave_state_e    st;
		logic [3:0]      bitc;
		logic [7:0]      sh;
		logic [4:0]      ptr;
		logic            rw;
		logic            sda_oe;
		logic            active;
		logic            scl_d;
		logic            sda_d;
		logic [7:0][7:0] intern;
		logic [7:0][7:0] user;
		logic [7:0]      ctrl;
		logic            freeze;
		logic [17:0]     div;
		logic [7:0]      rec;
		logic            protect;
	} slave_s;
	typedef struct packed {
		host_op_e    op;
		logic        nack;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic        got_nack;
		logic        scl_oe;
		logic        sda_oe;
		logic [1:0]  ph;
		logic [3:0]  bitn;
		logic [4:0]  qc;
		logic [7:0]  wait_c;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} host_s;
endpackage
`default_nettype wire

//--- logic/two_wire_if.sv
// Open-drain two-wire bus joining the controller and the clock device.
`timescale 1ns/100ps
`default_nettype none
interface two_wire_if;
	logic host_scl_oe;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// A line is low whenever any end enables its driver; pull-ups hold it high otherwise.
	assign scl = !host_scl_oe;
	assign sda = !(host_sda_oe | dev_sda_oe);
	modport host(output host_scl_oe, output host_sda_oe, input scl, input sda);
	modport dev(output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

//--- logic/rtc_sync2.sv
// Two-flop synchroniser for the device's asynchronous inputs.
`timescale 1ns/100ps
`default_nettype none
module rtc_sync2 import rtc_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [3:0] d_i,
	output logic      [3:0] q_o
);
	sync_s q;
	sync_s next_q;
	always_comb begin
		next_q.s1 = d_i;
		next_q.s2 = q.s1;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
	assign q_o = q.s2;
endmodule // rtc_sync2
`default_nettype wire

//--- logic/rtc_device.sv
// Clock device: two-wire slave access path with timekeeping registers.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_params.svh"
module rtc_device import rtc_pkg::*; #(
	parameter int HUNDREDTH_CYCLES = `RTC_HUNDREDTH_NS / `RTC_CLK_NS
) (
	input  wire logic clk_i,
	input  wire logic reset_i,
	two_wire_if.dev   bus,
	input  wire logic supply_switch_low_i,
	input  wire logic supply_clear_low_i,
	output logic      write_protect_o,
	output logic      osc_running_o
);
	slave_s     q;
	slave_s     next_q;
	logic [3:0] pins;
	logic       scl;
	logic       sda;
	logic       sw_low;
	logic       clr_low;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;
	logic       tick;
	logic       cy;
	logic       hold;
	logic [8:0] c;
	logic [7:0] wval;

	rtc_sync2 u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.d_i     ({supply_clear_low_i, supply_switch_low_i, bus.sda, bus.scl}),
		.q_o     (pins)
	);
	assign scl     = pins[0];
	assign sda     = pins[1];
	assign sw_low  = pins[2];
	assign clr_low = pins[3];
	assign rise    = scl & !q.scl_d;
	assign fall    = !scl & q.scl_d;
	assign start   = scl & q.scl_d & q.sda_d & !sda;
	assign stop    = scl & q.scl_d & !q.sda_d & sda;

	// BCD increment with wrap; bit 8 is the carry into the next field.
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
			input logic [7:0] first);
		if (v >= top) begin
			bcd_inc = {1'b1, first};
		end else if (v[3:0] >= 4'h9) begin
			bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h02: month_len = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
			default: month_len = 8'h31;
		endcase
	endfunction

	function automatic logic [7:0] reg_read(input slave_s s, input logic [4:0] a);
		if (a < `RTC_CLOCK_REGS) begin
			reg_read = s.user[a[2:0]];
		end else if (a == `RTC_CTRL_REG) begin
			reg_read = s.ctrl;
		end else if (a == `RTC_FREEZE_REG) begin
			reg_read = 8'h00;
			reg_read[`RTC_FREEZE_BIT] = s.freeze;
		end else begin
			reg_read = 8'h00;
		end
	endfunction

	function automatic logic [4:0] ptr_next(input logic [4:0] p);
		ptr_next = (p >= `RTC_LAST_REG) ? 5'h00 : p + 5'h01;
	endfunction

	always_comb begin
		next_q = q;
		next_q.scl_d = scl;
		next_q.sda_d = sda;
		tick = 1'b0;
		cy = 1'b0;
		c = '0;
		wval = '0;
		// Recovery window after the supply comes back above the clear threshold.
		if (clr_low) begin
			next_q.rec = 8'(`RTC_RECOVERY_CYC);
			next_q.ctrl[`RTC_FREQ_TEST_BIT] = 1'b0;
		end else if (q.rec != 8'h00) begin
			next_q.rec = q.rec - 8'h01;
		end
		next_q.protect = clr_low | (q.rec != 8'h00);
		if (q.intern[1][`RTC_HALT_BIT]) begin
			next_q.div = '0;
		end else if (q.div == 18'(HUNDREDTH_CYCLES - 1)) begin
			next_q.div = '0;
			tick = 1'b1;
		end else begin
			next_q.div = q.div + 18'h1;
		end
		if (tick) begin
			c = bcd_inc(q.intern[0], 8'h99, 8'h00);
			next_q.intern[0] = c[7:0];
			cy = c[8];
			if (cy) begin
				c = bcd_inc({1'b0, q.intern[1][6:0]}, 8'h59, 8'h00);
				next_q.intern[1][6:0] = c[6:0];
				cy = c[8];
			end
			if (cy) begin
				c = bcd_inc(q.intern[2], 8'h59, 8'h00);
				next_q.intern[2] = c[7:0];
				cy = c[8];
			end
			if (cy) begin
				c = bcd_inc({2'b00, q.intern[3][5:0]}, 8'h23, 8'h00);
				next_q.intern[3][5:0] = c[5:0];
				cy = c[8];
			end
			if (cy) begin
				c = bcd_inc({5'b0, q.intern[4][2:0]}, 8'h07, 8'h01);
				next_q.intern[4][2:0] = c[2:0];
				c = bcd_inc(q.intern[5], month_len(q.intern[6], q.intern[7]), 8'h01);
				next_q.intern[5] = c[7:0];
				cy = c[8];
			end
			if (cy) begin
				c = bcd_inc(q.intern[6], 8'h12, 8'h01);
				next_q.intern[6] = c[7:0];
				cy = c[8];
			end
			if (cy) begin
				c = bcd_inc(q.intern[7], 8'h99, 8'h00);
				next_q.intern[7] = c[7:0];
				cy = c[8];
			end
			if (cy && q.intern[3][`RTC_CEN_EN_BIT]) begin
				next_q.intern[3][`RTC_CEN_FLAG_BIT] = !q.intern[3][`RTC_CEN_FLAG_BIT];
			end
		end
		// User copies follow the counters unless frozen or clock addresses are selected.
		hold = q.freeze | (q.active & (q.ptr < `RTC_CLOCK_REGS));
		if (!hold) begin
			next_q.user = q.intern;
		end
		if (sw_low) begin
			next_q.st = S_IDLE;
			next_q.ptr = 5'h00;
			next_q.sda_oe = 1'b0;
			next_q.active = 1'b0;
			next_q.freeze = 1'b1;
		end else if (start) begin
			next_q.st = S_ADDR;
			next_q.bitc = 4'h0;
			next_q.sda_oe = 1'b0;
		end else if (stop) begin
			next_q.st = S_IDLE;
			next_q.active = 1'b0;
			next_q.sda_oe = 1'b0;
		end else begin
			unique case (q.st)
				S_IDLE, S_WAIT: begin
				end
				S_ADDR, S_PTR, S_WDAT: begin
					if (rise) begin
						next_q.sh = {q.sh[6:0], sda};
						next_q.bitc = q.bitc + 4'h1;
					end else if (fall && q.bitc == 4'h8) begin
						next_q.sda_oe = 1'b1;
						next_q.bitc = 4'h0;
						if (q.st == S_ADDR) begin
							if (q.sh[7:1] == `RTC_SLAVE_ADDR) begin
								next_q.rw = q.sh[0];
								next_q.active = 1'b1;
								next_q.st = S_ADDR_ACK;
							end else begin
								next_q.sda_oe = 1'b0;
								next_q.st = S_WAIT;
							end
						end else if (q.st == S_PTR) begin
							next_q.ptr = (q.sh > {3'b0, `RTC_LAST_REG}) ? 5'h00 : q.sh[4:0];
							next_q.st = S_PTR_ACK;
						end else begin
							next_q.st = S_WDAT_ACK;
							if (!q.protect && !clr_low) begin
								if (q.ptr < `RTC_CLOCK_REGS) begin
									wval = (q.ptr == 5'h00) ? 8'h00 : q.sh;
									next_q.intern[q.ptr[2:0]] = wval;
									next_q.user[q.ptr[2:0]] = wval;
									next_q.intern[0] = 8'h00;
									next_q.user[0] = 8'h00;
									next_q.div = '0;
								end else if (q.ptr == `RTC_CTRL_REG) begin
									next_q.ctrl = q.sh;
								end else if (q.ptr == `RTC_FREEZE_REG) begin
									next_q.freeze = q.sh[`RTC_FREEZE_BIT];
								end
							end
						end
					end
				end
				S_ADDR_ACK: begin
					if (fall) begin
						if (q.rw) begin
							next_q.sh = reg_read(q, q.ptr);
							next_q.sda_oe = !next_q.sh[7];
							next_q.st = S_RDAT;
						end else begin
							next_q.sda_oe = 1'b0;
							next_q.st = S_PTR;
						end
					end
				end
				S_PTR_ACK: begin
					if (fall) begin
						next_q.sda_oe = 1'b0;
						next_q.st = S_WDAT;
					end
				end
				S_WDAT_ACK: begin
					if (fall) begin
						next_q.sda_oe = 1'b0;
						next_q.ptr = ptr_next(q.ptr);
						next_q.st = S_WDAT;
					end
				end
				S_RDAT: begin
					if (fall) begin
						if (q.bitc == 4'h7) begin
							next_q.sda_oe = 1'b0;
							next_q.bitc = 4'h0;
							next_q.st = S_RACK;
						end else begin
							next_q.bitc = q.bitc + 4'h1;
							next_q.sh = {q.sh[6:0], 1'b0};
							next_q.sda_oe = !q.sh[6];
						end
					end
				end
				S_RACK: begin
					if (rise) begin
						if (!sda) begin
							next_q.ptr = ptr_next(q.ptr);
							next_q.bitc = 4'h1;
						end else begin
							next_q.st = S_WAIT;
						end
					end else if (fall && q.bitc == 4'h1) begin
						next_q.sh = reg_read(q, q.ptr);
						next_q.sda_oe = !next_q.sh[7];
						next_q.bitc = 4'h0;
						next_q.st = S_RDAT;
					end
				end
				default: begin
					next_q.st = S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign bus.dev_sda_oe = q.sda_oe;
	assign write_protect_o = q.protect;
	assign osc_running_o = !q.intern[1][`RTC_HALT_BIT];
endmodule // rtc_device
`default_nettype wire

//--- logic/rtc_host.sv
// Two-wire bus controller driven by software through APB registers.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_params.svh"
module rtc_host import rtc_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	two_wire_if.host         bus
);
	host_s q;
	host_s next_q;
	logic  bus_ready;
	logic  qtick;
	logic  bitval;

	assign bus_ready = (q.wait_c == 8'(`RTC_RECOVERY_CYC));

	always_comb begin
		next_q = q;
		next_q.pready = 1'b0;
		next_q.pslverr = 1'b0;
		qtick = 1'b0;
		// Lines stay released for the recovery time before the first command.
		if (!bus_ready) begin
			next_q.wait_c = q.wait_c + 8'h01;
		end
		if (q.qc == 5'(`RTC_QUARTER_CYC - 1)) begin
			next_q.qc = 5'h00;
			qtick = 1'b1;
		end else begin
			next_q.qc = q.qc + 5'h01;
		end
		if (psel_i && !penable_i) begin
			next_q.pready = 1'b1;
			next_q.prdata = '0;
			case (paddr_i)
				`RTC_APB_CMD: next_q.prdata = {29'h0, q.op};
				`RTC_APB_TX: next_q.prdata = {24'h0, q.tx};
				`RTC_APB_STAT: next_q.prdata = {29'h0, bus_ready, q.got_nack, q.op != OP_NONE};
				`RTC_APB_RX: next_q.prdata = {24'h0, q.rx};
				default: next_q.pslverr = 1'b1;
			endcase
		end
		if (psel_i && penable_i && q.pready && pwrite_i) begin
			if (paddr_i == `RTC_APB_TX) begin
				next_q.tx = pwdata_i[7:0];
			end else if (paddr_i == `RTC_APB_CMD && q.op == OP_NONE && bus_ready
					&& pwdata_i[2:0] != 3'h0 && pwdata_i[2:0] <= OP_READ) begin
				next_q.op = host_op_e'(pwdata_i[2:0]);
				next_q.nack = pwdata_i[`RTC_CMD_NACK_BIT];
				next_q.ph = 2'h0;
				next_q.bitn = 4'h0;
				next_q.qc = 5'h00;
			end
		end
		// Ninth bit releases the line on writes, and sends ack or no-ack on reads.
		if (q.bitn[3]) begin
			bitval = (q.op == OP_WRITE) ? 1'b1 : q.nack;
		end else begin
			bitval = (q.op == OP_WRITE) ? q.tx[~q.bitn[2:0]] : 1'b1;
		end
		if (qtick && q.op != OP_NONE) begin
			next_q.ph = q.ph + 2'h1;
			unique case (q.ph)
				2'h0: begin
					next_q.sda_oe = (q.op == OP_STOP) ? 1'b1 : (q.op == OP_START) ? 1'b0 : !bitval;
				end
				2'h1: begin
					next_q.scl_oe = 1'b0;
				end
				2'h2: begin
					if (q.op == OP_START) begin
						next_q.sda_oe = 1'b1;
					end else if (q.op == OP_STOP) begin
						next_q.sda_oe = 1'b0;
					end else if (!q.bitn[3]) begin
						next_q.rx = {q.rx[6:0], bus.sda};
					end else if (q.op == OP_WRITE) begin
						next_q.got_nack = bus.sda;
					end
				end
				2'h3: begin
					if (q.op != OP_STOP) begin
						next_q.scl_oe = 1'b1;
					end
					if (q.op == OP_START || q.op == OP_STOP || q.bitn[3]) begin
						next_q.op = OP_NONE;
					end else begin
						next_q.bitn = q.bitn + 4'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign bus.host_scl_oe = q.scl_oe;
	assign bus.host_sda_oe = q.sda_oe;
endmodule // rtc_host
`default_nettype wire

//--- testbench/rtc_link_monitor.sv
// Wire-level checker for the two-wire link between controller and clock device.
`timescale 1ns/100ps
`default_nettype none
module rtc_link_monitor (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	localparam int REC = 200;
	logic       scl_q;
	logic       sda_q;
	logic       act;
	logic       first;
	logic       wr;
	logic       ign;
	logic       rd_end;
	logic [3:0] bitn;
	logic [7:0] sh;
	logic [8:0] up;
	wire        rise = scl && !scl_q;
	wire        fall = !scl && scl_q;
	wire        strt = scl && scl_q && sda_q && !sda;
	wire        stp = scl && scl_q && !sda_q && sda;
	wire        ackb = rise && act && bitn == 4'h8;
	wire        mine = sh[7:1] == 7'h68;
	// Tracks framing, bit count and the byte just shifted, as any listener on the wire would.
	always_ff @(posedge clk_i) begin
		scl_q <= reset_i | scl;
		sda_q <= reset_i | sda;
		up <= reset_i ? 9'h0 : up + {8'h0, up != 9'h1ff};
		if (reset_i || stp) begin
			act <= 1'b0;
			ign <= 1'b0;
			rd_end <= 1'b0;
		end else if (strt) begin
			act <= 1'b1;
			first <= 1'b1;
			bitn <= 4'h0;
			ign <= 1'b0;
			rd_end <= 1'b0;
		end else if (ackb) begin
			bitn <= 4'h0;
			first <= 1'b0;
			wr <= first ? !sh[0] : wr;
			ign <= ign | (first & !mine);
			rd_end <= !first && !wr && sda;
		end else if (rise) begin
			sh <= {sh[6:0], sda};
			bitn <= bitn + 4'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	AST_ADDR_ACK: assert property (ackb && first && mine |-> !sda)
		else $error("own address not acknowledged");
	AST_ADDR_NOACK: assert property (ackb && first && !mine |-> sda)
		else $error("foreign address acknowledged");
	AST_IGNORED: assert property (ign |-> !dev_sda_oe)
		else $error("device drives after foreign address");
	AST_DATA_ACK: assert property (ackb && !first && wr && !ign |-> !sda)
		else $error("written byte not acknowledged");
	AST_ACK_DELAY: assert property (fall && act && bitn == 4'h8 && !ign && (first ? mine : wr)
		|-> ##[1:8] dev_sda_oe)
		else $error("acknowledge late after clock fall");
	AST_STABLE_HIGH: assert property (scl && scl_q |-> $stable(dev_sda_oe))
		else $error("device changed data while clock high");
	AST_READ_END: assert property (rd_end |-> !dev_sda_oe)
		else $error("device drives after missing acknowledge");
	AST_REC_IDLE: assert property (strt |-> up >= REC)
		else $error("start inside recovery interval");
	AST_RESET_REL: assert property ($fell(reset_i) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
		else $error("line driven at reset release");
	cover property (ackb && first && !mine);
	cover property (rd_end);
	cover property (ackb && !first && wr);
	cover property (strt && act);
endmodule // rtc_link_monitor
`default_nettype wire

//--- testbench/serial_rtc_register_access_tb_top.sv
// Self-checking bench: controller and clock device joined on one two-wire link.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_params.svh"
module serial_rtc_register_access_tb_top import rtc_pkg::*; ;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  paddr = 8'h0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sw_low = 1'b0;
	logic        clr_low = 1'b0;
	logic        wp;
	logic        osc;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  q [$];
	logic [7:0]  w [8];
	logic [7:0]  ctl;
	logic [7:0]  sec;
	logic [7:0]  v;
	int          failures = 0;
	int          n_checks = 0;
	int          cyc = 0;
	two_wire_if link ();
	rtc_host i_rtc_host (.clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .bus(link.host));
	rtc_device #(.HUNDREDTH_CYCLES(4)) i_rtc_device (.clk_i(clk_i), .reset_i(reset_i),
		.bus(link.dev), .supply_switch_low_i(sw_low), .supply_clear_low_i(clr_low),
		.write_protect_o(wp), .osc_running_o(osc));
	rtc_link_monitor i_rtc_link_monitor (.clk_i(clk_i), .reset_i(reset_i),
		.host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
	always #25 clk_i = ~clk_i;
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 95000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, want);
		n_checks++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic idle();
		do begin
			apb(1'b0, `RTC_APB_STAT, 32'h0, rd, er);
		end while (rd[0] !== 1'b0);
	endtask
	task automatic op(input logic [8:0] c, input logic [7:0] tx);
		idle();
		if (c[2:0] == 3'h3)
			apb(1'b1, `RTC_APB_TX, {24'h0, tx}, rd, er);
		apb(1'b1, `RTC_APB_CMD, {23'h0, c}, rd, er);
	endtask
	// Pointer byte, then every byte of q, then STOP.
	task automatic xwrite(input logic [7:0] p);
		op(9'h1, 8'h0);
		op(9'h3, 8'hd0);
		op(9'h3, p);
		foreach (q[i]) op(9'h3, q[i]);
		op(9'h2, 8'h0);
		idle();
	endtask
	// Reads n bytes into q, from p when pt is set, else from the held pointer.
	task automatic xread(input logic pt, input logic [7:0] p, input int n);
		q = {};
		op(9'h1, 8'h0);
		if (pt) begin
			op(9'h3, 8'hd0);
			op(9'h3, p);
			op(9'h1, 8'h0);
		end
		op(9'h3, 8'hd1);
		for (int i = 0; i < n; i++) begin
			op({i == n - 1, 8'h4}, 8'h0);
			idle();
			apb(1'b0, `RTC_APB_RX, 32'h0, rd, er);
			q.push_back(rd[7:0]);
		end
		op(9'h2, 8'h0);
		idle();
	endtask
	function automatic logic [7:0] bcd(input int lo, hi);
		int x;
		x = $urandom_range(hi, lo);
		return {4'(x / 10), 4'(x % 10)};
	endfunction
	initial begin
		void'($urandom(32'hbc54));
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (210) @(posedge clk_i);
		apb(1'b1, 8'h10, 32'h5a, rd, er);
		chk("unmapped_err", er, 1'b1);
		w[0] = 8'($urandom);
		w[1] = 8'h80 | bcd(0, 59);
		w[2] = bcd(0, 59);
		w[3] = bcd(0, 23) | {2'($urandom), 6'h00};
		w[4] = bcd(1, 7);
		w[5] = bcd(1, 28);
		w[6] = bcd(1, 12);
		w[7] = bcd(0, 99);
		q = {};
		foreach (w[i]) q.push_back(w[i]);
		xwrite(8'h00);
		chk("osc_stopped", osc, 1'b0);
		xread(1'b1, 8'h00, 8);
		foreach (w[i]) chk("clock_reg", q[i], i == 0 ? 8'h00 : w[i]);
		ctl = 8'($urandom) | 8'h40;
		q = {ctl};
		xwrite(8'h08);
		q = {};
		xwrite(8'h08);
		xread(1'b0, 8'h00, 1);
		chk("current_read", q[0], ctl);
		xread(1'b1, 8'h13, 3);
		chk("wrap_13", q[0], 8'h00);
		chk("wrap_00", q[1], 8'h00);
		chk("wrap_01", q[2], w[1]);
		repeat (3) begin
			v = 8'($urandom) & 8'hfe;
			if (v == 8'hd0)
				v = 8'h20;
			op(9'h1, 8'h0);
			op(9'h3, v);
			idle();
			apb(1'b0, `RTC_APB_STAT, 32'h0, rd, er);
			chk("foreign_nack", rd[1], 1'b1);
			op(9'h2, 8'h0);
		end
		clr_low <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk("protect_on", wp, 1'b1);
		q = {8'h00};
		xwrite(8'h08);
		xread(1'b1, 8'h08, 1);
		chk("ctl_kept", q[0], ctl & 8'hbf);
		clr_low <= 1'b0;
		repeat (20) @(posedge clk_i);
		chk("protect_held", wp, 1'b1);
		repeat (200) @(posedge clk_i);
		chk("protect_off", wp, 1'b0);
		q = {8'h00};
		xwrite(8'h01);
		chk("osc_running", osc, 1'b1);
		repeat (1300) @(posedge clk_i);
		xread(1'b1, 8'h01, 1);
		sec = q[0];
		chk("sec_advance", sec != 8'h00, 1'b1);
		chk("sec_bcd", sec[3:0] < 4'ha, 1'b1);
		q = {};
		xwrite(8'h08);
		sw_low <= 1'b1;
		repeat (10) @(posedge clk_i);
		sw_low <= 1'b0;
		repeat (250) @(posedge clk_i);
		xread(1'b0, 8'h00, 2);
		sec = q[1];
		chk("ptr_reset", sec != 8'h00, 1'b1);
		xread(1'b1, 8'h0c, 1);
		chk("freeze_set", q[0][6], 1'b1);
		repeat (1300) @(posedge clk_i);
		xread(1'b1, 8'h01, 1);
		chk("frozen_sec", q[0], sec);
		q = {8'h00};
		xwrite(8'h0c);
		repeat (1300) @(posedge clk_i);
		xread(1'b1, 8'h01, 1);
		chk("resumed_sec", q[0] != sec, 1'b1);
		end_of_test();
	end
endmodule // serial_rtc_register_access_tb_top
`default_nettype wire
